// ### hw/cbcr_regs.sv
`default_nettype none
module cbcr_regs
  import cbcr_pkg::*;
#(
  parameter logic [3:0] REV_CODE   = 4'h1, // Arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3C, // Arbitrary value
  parameter int         NUM_CH     = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] oe_pin_n,
  output logic [7:0]      ch_run,
  output logic [7:0]      sw_enable,
  output logic [4:0]      block_read_count,
  output logic            impedance_select,
  output logic            powerdown_drive_select
);
  if (NUM_CH != 8) begin : g_bad_num_ch
    $error("cbcr_regs: only eight channels are supported");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] oe_a_ff;
  logic [7:0] oe_b_ff;
  logic [7:0] bytecnt_ff;
  logic [7:0] output_settings_ff;
  logic [7:0] rdata_ff;
  logic [7:0] ch_run_ff;
  logic [7:0] pin_sync;

  cbcr_sync2 #(
    .WIDTH(8)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (oe_pin_n),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire wr_oe_a   = reg_wr_en && (reg_addr == CBCR_ADDR_OE_A);
  wire wr_oe_b   = reg_wr_en && (reg_addr == CBCR_ADDR_OE_B);
  wire wr_bytecn = reg_wr_en && (reg_addr == CBCR_ADDR_BYTECNT);
  wire wr_output_settings = reg_wr_en && (reg_addr == CBCR_ADDR_OUTPUT_SETTINGS);

  // Read-only bits keep their stored value on write
  wire [7:0] nxt_output_settings = (reg_wdata & CBCR_OUTPUT_SETTINGS_WMASK)
    | (output_settings_ff & ~CBCR_OUTPUT_SETTINGS_WMASK);

  wire [7:0] sw_en_vec = {
    oe_b_ff[CBCR_B_CH7], oe_b_ff[CBCR_B_CH6],
    oe_a_ff[CBCR_A_CH5], oe_a_ff[CBCR_A_CH4],
    oe_a_ff[CBCR_A_CH3], oe_a_ff[CBCR_A_CH2],
    oe_a_ff[CBCR_A_CH1], oe_a_ff[CBCR_A_CH0]};

  // Pins are active low; software bit gates the pin request
  wire [7:0] nxt_ch_run = sw_en_vec & ~pin_sync;

  wire [7:0] vendrev = {REV_CODE, MAKER_CODE};

  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      CBCR_ADDR_OE_A:    rd_mux = oe_a_ff;
      CBCR_ADDR_OE_B:    rd_mux = oe_b_ff;
      CBCR_ADDR_PIN_RB:  rd_mux = pin_sync;
      CBCR_ADDR_RSVD:    rd_mux = CBCR_ZERO_BYTE;
      CBCR_ADDR_VENDREV: rd_mux = vendrev;
      CBCR_ADDR_PARTID:  rd_mux = PART_CODE;
      CBCR_ADDR_BYTECNT: rd_mux = bytecnt_ff;
      CBCR_ADDR_OUTPUT_SETTINGS:  rd_mux = output_settings_ff;
      default:           rd_mux = CBCR_ZERO_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_a_ff    <= CBCR_RST_OE_A;
      oe_b_ff    <= CBCR_RST_OE_B;
      bytecnt_ff <= CBCR_RST_BYTECNT;
      output_settings_ff  <= CBCR_RST_OUTPUT_SETTINGS;
    end else begin
      if (wr_oe_a) oe_a_ff <= reg_wdata;
      if (wr_oe_b) oe_b_ff <= reg_wdata;
      if (wr_bytecn) bytecnt_ff <= reg_wdata;
      if (wr_output_settings) output_settings_ff <= nxt_output_settings;
    end
  end

  // Read data is registered so every output comes from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff  <= CBCR_ZERO_BYTE;
      ch_run_ff <= CBCR_ZERO_BYTE;
    end else begin
      if (reg_rd_en) rdata_ff <= rd_mux;
      ch_run_ff <= nxt_ch_run;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign ch_run                 = ch_run_ff;
  assign sw_enable              = sw_en_vec;
  assign block_read_count       = bytecnt_ff[CBCR_CNT_BITS-1:0];
  assign impedance_select       = output_settings_ff[CBCR_BIT_IMPED];
  assign powerdown_drive_select = output_settings_ff[CBCR_BIT_PDDRV];

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, seen on the first edge after release
  chk_oe_a_reset: assert property (
    @(posedge sys_clk) $fell(rst) |-> oe_a_ff == CBCR_RST_OE_A)
    else $error("oe_a reset wrong");
  chk_oe_b_reset: assert property (
    @(posedge sys_clk) $fell(rst) |-> oe_b_ff == CBCR_RST_OE_B)
    else $error("oe_b reset wrong");
  chk_cnt_reset: assert property (
    @(posedge sys_clk) $fell(rst) |-> bytecnt_ff == CBCR_RST_BYTECNT)
    else $error("byte count reset wrong");
  chk_output_settings_reset: assert property (
    @(posedge sys_clk) $fell(rst) |-> output_settings_ff == CBCR_RST_OUTPUT_SETTINGS)
    else $error("settings reset wrong");

  // Stored bytes move only on their own write strobe
  chk_oe_a_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_oe_a |=> oe_a_ff == $past(reg_wdata))
    else $error("oe_a not stored");
  chk_oe_a_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wr_oe_a |=> $stable(oe_a_ff))
    else $error("oe_a changed without write");
  chk_oe_b_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_oe_b |=> oe_b_ff == $past(reg_wdata))
    else $error("oe_b not stored");
  chk_oe_b_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wr_oe_b |=> $stable(oe_b_ff))
    else $error("oe_b changed without write");
  chk_cnt_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_bytecn |=> block_read_count == $past(reg_wdata[4:0]))
    else $error("byte count not stored");
  chk_cnt_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wr_bytecn |=> $stable(bytecnt_ff))
    else $error("byte count changed without write");
  chk_imped_wr: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_output_settings |=> impedance_select == $past(reg_wdata[5]))
    else $error("impedance not stored");
  chk_pdd_wr: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_output_settings |=> powerdown_drive_select == $past(reg_wdata[4]))
    else $error("power-down drive not stored");
  chk_output_settings_ro: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_output_settings |=> output_settings_ff[7:6] == $past(output_settings_ff[7:6]))
    else $error("read-only bits changed");
  chk_output_settings_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wr_output_settings |=> $stable(output_settings_ff))
    else $error("settings changed without write");
  chk_ro_nowrite: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_wr_en && reg_addr >= CBCR_ADDR_PIN_RB && reg_addr <= CBCR_ADDR_PARTID
    |=> $stable({oe_a_ff, oe_b_ff, bytecnt_ff, output_settings_ff}))
    else $error("read-only write changed storage");

  // Channel run gating against software bits and synced pins
  chk_ch_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    !sw_en_vec[5] |=> !ch_run_ff[5])
    else $error("ch5 not gated");
  chk_gate_all: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ch_run_ff & ~$past(sw_en_vec)) == 8'h00)
    else $error("disabled channel running");
  chk_ch_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    oe_b_ff[CBCR_B_CH7] |=> ch_run_ff[7] == !$past(pin_sync[7]))
    else $error("ch7 wrong");
  chk_ch0_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    oe_a_ff[CBCR_A_CH0] |=> ch_run_ff[0] == !$past(pin_sync[0]))
    else $error("ch0 wrong");

  // Read data lands one edge after the read strobe
  chk_rsvd_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == CBCR_ADDR_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved byte nonzero");
  chk_pin_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == CBCR_ADDR_PIN_RB |=> reg_rdata == $past(pin_sync))
    else $error("pin readback wrong");
  chk_part_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == CBCR_ADDR_PARTID |=> reg_rdata == PART_CODE)
    else $error("part code wrong");
  chk_vend_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == CBCR_ADDR_VENDREV
    |=> reg_rdata == {REV_CODE, MAKER_CODE})
    else $error("vendor code wrong");
  chk_cnt_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd_en && reg_addr == CBCR_ADDR_BYTECNT
    |=> reg_rdata == $past(bytecnt_ff))
    else $error("byte count readback wrong");
endmodule
`default_nettype wire

// ### hw/cbcr_sync2.sv
`default_nettype none
module cbcr_sync2
  import cbcr_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("cbcr_sync2: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ### inc/cbcr_pkg.sv
`default_nettype none
package cbcr_pkg;
  localparam logic [7:0] CBCR_ADDR_OE_A     = 8'h01;
  localparam logic [7:0] CBCR_ADDR_OE_B     = 8'h02;
  localparam logic [7:0] CBCR_ADDR_PIN_RB   = 8'h03;
  localparam logic [7:0] CBCR_ADDR_RSVD     = 8'h04;
  localparam logic [7:0] CBCR_ADDR_VENDREV  = 8'h05;
  localparam logic [7:0] CBCR_ADDR_PARTID   = 8'h06;
  localparam logic [7:0] CBCR_ADDR_BYTECNT  = 8'h07;
  localparam logic [7:0] CBCR_ADDR_OUTPUT_SETTINGS   = 8'h08;
  localparam logic [7:0] CBCR_RST_OE_A      = 8'hFF;
  localparam logic [7:0] CBCR_RST_OE_B      = 8'h0F;
  localparam logic [7:0] CBCR_RST_BYTECNT   = 8'h08;
  localparam logic [7:0] CBCR_RST_OUTPUT_SETTINGS    = 8'h00;
  localparam logic [7:0] CBCR_ZERO_BYTE     = 8'h00;
  localparam int         CBCR_CNT_BITS      = 5;
  localparam int         CBCR_BIT_IMPED     = 5;
  localparam int         CBCR_BIT_PDDRV     = 4;
  // Writable settings bits: impedance, power-down drive, low nibble
  localparam logic [7:0] CBCR_OUTPUT_SETTINGS_WMASK  = 8'h3F;
  // Placement of channel enables in the two control bytes
  localparam int CBCR_A_CH0 = 1;
  localparam int CBCR_A_CH1 = 2;
  localparam int CBCR_A_CH2 = 4;
  localparam int CBCR_A_CH3 = 5;
  localparam int CBCR_A_CH4 = 6;
  localparam int CBCR_A_CH5 = 7;
  localparam int CBCR_B_CH6 = 0;
  localparam int CBCR_B_CH7 = 2;
endpackage
`default_nettype wire

// ### verif/cbcr_host.sv
`default_nettype none
// Host controller model: one byte per strobe, driven on falling edges
module cbcr_host (
  input  wire logic       sys_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    // Settings low nibble must stay zero
    reg_wdata = (a == 8'h08) ? (d & 8'hF0) : d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    // Released lines show no stale value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_clock_buffer_config_registers.sv
`default_nettype none
module tb_clock_buffer_config_registers
  import cbcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV = 4'h2;   // Arbitrary value
  localparam logic [3:0] MKR = 4'h9;   // Arbitrary value
  localparam logic [7:0] PRT = 8'h5A;  // Arbitrary value
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr_en, rd_en, imp, pdd;
  logic [7:0] addr, wdata, rdata, ch_run, sw_en;
  logic [7:0] pins = 8'h0F;
  logic [4:0] cnt;
  int         n_fail = 0;
  int         n_compared = 0;
  int         cyc = 0;
  cbcr_host host_i (.sys_clk(sys_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  cbcr_regs #(.REV_CODE(REV), .MAKER_CODE(MKR), .PART_CODE(PRT)) cbcr_regs_i (
    .sys_clk(sys_clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .oe_pin_n(pins),
    .ch_run(ch_run), .sw_enable(sw_en), .block_read_count(cnt),
    .impedance_select(imp), .powerdown_drive_select(pdd));
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic final_report;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Run time is under a hundred cycles; ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic t_reset;
    rchk(CBCR_ADDR_OE_A, 8'hFF);
    rchk(CBCR_ADDR_OE_B, 8'h0F);
    rchk(CBCR_ADDR_BYTECNT, 8'h08);
    rchk(CBCR_ADDR_OUTPUT_SETTINGS, 8'h00);
    chk(sw_en, 8'hFF);
    chk({3'h0, cnt}, 8'h08);
    chk({6'h0, imp, pdd}, 8'h00);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_readonly;
    for (int a = 3; a <= 6; a++) host_i.wr(8'(a), 8'hA5);
    rchk(CBCR_ADDR_PIN_RB, 8'h0F);
    rchk(CBCR_ADDR_RSVD, 8'h00);
    rchk(CBCR_ADDR_VENDREV, {REV, MKR});
    rchk(CBCR_ADDR_PARTID, PRT);
  endtask
  task automatic t_enables;
    host_i.wr(CBCR_ADDR_OE_A, 8'h56);
    host_i.wr(CBCR_ADDR_OE_B, 8'h04);
    repeat (4) @(negedge sys_clk);
    chk(sw_en, 8'h97);
    chk(ch_run, 8'h90);
    pins = 8'h00;
    repeat (4) @(negedge sys_clk);
    chk(ch_run, 8'h97);
    rchk(CBCR_ADDR_PIN_RB, 8'h00);
    rchk(CBCR_ADDR_OE_A, 8'h56);
    rchk(CBCR_ADDR_OE_B, 8'h04);
  endtask
  task automatic t_settings;
    host_i.wr(CBCR_ADDR_OUTPUT_SETTINGS, 8'hFF);
    rchk(CBCR_ADDR_OUTPUT_SETTINGS, 8'h30);
    chk({6'h0, imp, pdd}, 8'h03);
    host_i.wr(CBCR_ADDR_OUTPUT_SETTINGS, 8'h20);
    chk({6'h0, imp, pdd}, 8'h02);
    host_i.wr(CBCR_ADDR_BYTECNT, 8'hF3);
    rchk(CBCR_ADDR_BYTECNT, 8'hF3);
    chk({3'h0, cnt}, 8'h13);
  endtask
  // Mid-run reset must restore every stored byte
  task automatic t_rerst;
    @(negedge sys_clk);
    rst  = 1'b1;
    pins = 8'h81;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    chk(ch_run, 8'h7E);
    rchk(CBCR_ADDR_PIN_RB, 8'h81);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_readonly();
    t_enables();
    t_settings();
    t_rerst();
    final_report();
  end
endmodule
`default_nettype wire
